// ### verif/spieb_slave_model.sv
// behavioural serial slave standing on the far side of the master port
module spieb_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial miso = 1'b0;
	initial rx_byte = 8'h00;
	// mode 0: first bit ready at select, next one after each falling edge
	always @(posedge sel) begin
		sh = tx_byte;
		miso = tx_byte[7];
		rx_byte = 8'h00;
	end
	always @(posedge sck) rx_byte = {rx_byte[6:0], mosi};
	always @(negedge sck) if (sel) begin
		sh = {sh[6:0], 1'b0};
		miso = sh[7];
	end
	// no pull on the line: show the inverse so a stale bit cannot pass
	always @(negedge sel) miso = ~miso;
endmodule

// ### verif/test_spieb_top.sv
// self-checking bench for flags, completion interrupts and baud divider
`define CHK(e, g, nm) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_spieb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic spi_enable = 1'b0, master_mode = 1'b0, irq_enable = 1'b0, timer_run = 1'b0;
	logic [2:0] char_length_field = 3'h0;
	logic [7:0] wr_data = 8'h00;
	logic data_wr = 1'b0, stat_wr = 1'b0, baud_hi_wr = 1'b0, baud_lo_wr = 1'b0;
	logic ss_n_in = 1'b1, sel = 1'b0;
	logic sck_out, sck_oe, mosi_out, mosi_oe, busy, irq, miso_in;
	logic [7:0] rx_data, serial_status_reg, m_rx;
	logic [7:0] tx_byte = 8'h00;
	logic [15:0] baud_divisor_reload;
	int errors = 0, n_checks = 0, cyc = 0, cur_r = 2, k = 0;

	always #12.5 clk = ~clk;

	spieb_top u_spieb_top (.clk, .rst_n, .spi_enable, .master_mode, .irq_enable,
		.timer_run, .char_length_field, .wr_data, .data_wr, .stat_wr, .baud_hi_wr,
		.baud_lo_wr, .ss_n_in, .miso_in, .sck_out, .sck_oe, .mosi_out, .mosi_oe,
		.rx_data, .baud_divisor_reload, .serial_status_reg, .busy, .irq);
	spieb_slave_model u_spieb_slave_model (.sck(sck_out), .mosi(mosi_out), .sel,
		.tx_byte, .miso(miso_in), .rx_byte(m_rx));

	////////////////////////////////////////////////////////////////////////////////
	task end_sim();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// whole run needs a few hundred cycles; a hang ends here
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_sim();
		end
	end

	// kind: 0 data, 1 status, 2 baud high, 3 baud low
	task wr(input int kind, input logic [7:0] v);
		@(negedge clk);
		wr_data = v;
		data_wr = (kind == 0);
		stat_wr = (kind == 1);
		baud_hi_wr = (kind == 2);
		baud_lo_wr = (kind == 3);
		@(negedge clk);
		{data_wr, stat_wr, baud_hi_wr, baud_lo_wr} = 4'h0;
	endtask

	task set_baud(input logic [15:0] r);
		wr(2, r[15:8]);
		wr(3, r[7:0]);
		cur_r = int'(r);
		`CHK(r, baud_divisor_reload, "reload")
	endtask

	task xfer(input int n, input logic [7:0] d, input logic [7:0] s, input bit coll);
		int nr, t1, t2;
		logic p;
		logic [7:0] m;
		nr = 0;
		t1 = 0;
		t2 = 0;
		p = 1'b0;
		m = 8'hFF >> (8 - n);
		tx_byte = s;
		sel = 1'b1;
		char_length_field = n[2:0];
		wr(0, d);
		`CHK(1'b1, serial_status_reg[1], "status busy")
		`CHK(2'h3, {sck_oe, mosi_oe}, "pins driven")
		if (coll) begin
			wr(0, ~d);
			`CHK(1'b1, serial_status_reg[6], "collision")
		end
		for (int i = 0; i < 4000 && busy; i++) begin
			@(negedge clk);
			if (sck_out && !p) begin
				nr++;
				t2 = t1;
				t1 = i;
			end
			p = sck_out;
		end
		`CHK(n, nr, "sck rises")
		if (n > 1) `CHK(2 * cur_r, t1 - t2, "sck period")
		// the low n bits of the written byte go out, msb of that field first
		`CHK(d & m, m_rx & m, "mosi bits")
		`CHK(s >> (8 - n), rx_data & m, "rx bits")
		`CHK(1'b1, irq, "master irq")
		sel = 1'b0;
		wr(1, 8'h80);
		`CHK(1'b0, irq, "irq clear")
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHK(8'h01, serial_status_reg, "status reset")
		`CHK(16'h0002, baud_divisor_reload, "reload reset")
		irq_enable = 1'b1;
		set_baud(16'hA55A);
		// reload kept at 2 or above for serial use
		set_baud(16'h0002);
		spi_enable = 1'b1;
		master_mode = 1'b1;
		for (int n = 1; n <= 8; n++) xfer(n, 8'(8'hB4 + n), 8'(8'h69 ^ n), 1'b0);
		$display("test master lengths done");
		set_baud(16'h0003);
		xfer(8, 8'hC3, 8'h3C, 1'b1);
		wr(1, 8'h00);
		`CHK(1'b1, serial_status_reg[6], "coll kept")
		wr(1, 8'h40);
		`CHK(1'b0, serial_status_reg[6], "coll clear")
		$display("test collision done");
		ss_n_in = 1'b0;
		repeat (2) @(negedge clk);
		ss_n_in = 1'b1;
		`CHK(1'b1, serial_status_reg[5], "mode fault")
		wr(1, 8'h00);
		`CHK(1'b1, serial_status_reg[5], "fault kept")
		wr(1, 8'h20);
		`CHK(1'b0, serial_status_reg[5], "fault clear")
		$display("test mode fault done");
		master_mode = 1'b0;
		for (int e = 1; e >= 0; e--) begin
			irq_enable = e[0];
			ss_n_in = 1'b0;
			@(negedge clk);
			`CHK(1'b1, busy, "slave busy")
			`CHK(2'h0, {sck_oe, mosi_oe}, "pins released")
			ss_n_in = 1'b1;
			repeat (2) @(negedge clk);
			`CHK(e[0], irq, "slave irq")
			wr(1, 8'h80);
			`CHK(1'b0, irq, "slave clear")
		end
		$display("test slave done");
		irq_enable = 1'b1;
		spi_enable = 1'b0;
		set_baud(16'h0005);
		timer_run = 1'b1;
		for (int i = 0; i < 50 && !irq; i++) @(negedge clk);
		`CHK(1'b1, irq, "timer irq")
		// clear in flight, then count cycles to the next time-out
		stat_wr = 1'b1;
		wr_data = 8'h80;
		do begin
			@(negedge clk);
			stat_wr = 1'b0;
			k++;
		end while (!irq && k < 50);
		`CHK(cur_r, k, "timer period")
		timer_run = 1'b0;
		$display("test timer done");
		end_sim();
	end
endmodule

// ### verilog/spieb_baud.sv
// 16-bit down-counting reload divider, serial clock half period or timer time-out
module spieb_baud #(
	parameter int WIDTH = spieb_pkg::BAUD_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [WIDTH-1:0] reload,
	output logic tick
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	////////////////////////////////////////////////////////////////////////
	// a reload of zero wraps through all ones and so acts as the full count
	always_comb begin
		tick = run && (cnt_q == WIDTH'(1));
		cnt_d = cnt_q;
		if (!run) begin
			cnt_d = reload;
		end else if (tick) begin
			cnt_d = reload;
		end else begin
			cnt_d = cnt_q - WIDTH'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= WIDTH'(spieb_pkg::BAUD_RESET);
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// ### verilog/spieb_pkg.sv
// constants and types shared by the serial error, interrupt and baud divider logic
package spieb_pkg;
	// system clock
	localparam int CLK_FREQ_MHZ = 40;
	localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;

	// status byte layout
	localparam int ST_IRQ_BIT = 7;
	localparam int ST_WCOL_BIT = 6;
	localparam int ST_COL_BIT = 5;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_SSIN_BIT = 0;

	// reset values
	localparam logic [15:0] BAUD_RESET = 16'h0002;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// divider limits and character length
	localparam logic [15:0] BAUD_MIN_RELOAD = 16'h0002;
	localparam int BAUD_W = 16;
	localparam int CHAR_LEN_W = 3;
	localparam logic [3:0] CHAR_MAX_BITS = 4'h8;

	// master shift sequencer states
	typedef enum logic [1:0] {
		SPIEB_IDLE = 2'b01,
		SPIEB_SHIFT = 2'b10
	} spieb_state_t;
endpackage

// ### verilog/spieb_top.sv
// serial interface error flags, completion interrupt and baud divider
////////////////////////////////////////////////////////////////////////////////
module spieb_top #(
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_enable,
	input wire logic master_mode,
	input wire logic irq_enable,
	input wire logic timer_run,
	input wire logic [spieb_pkg::CHAR_LEN_W-1:0] char_length_field,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic data_wr,
	input wire logic stat_wr,
	input wire logic baud_hi_wr,
	input wire logic baud_lo_wr,
	input wire logic ss_n_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic sck_oe,
	output logic mosi_out,
	output logic mosi_oe,
	output logic [DATA_W-1:0] rx_data,
	output logic [spieb_pkg::BAUD_W-1:0] baud_divisor_reload,
	output logic [7:0] serial_status_reg,
	output logic busy,
	output logic irq
);
	spieb_pkg::spieb_state_t state_q;
	spieb_pkg::spieb_state_t state_d;
	logic [DATA_W-1:0] shift_q;
	logic [DATA_W-1:0] shift_d;
	logic [DATA_W-1:0] rx_q;
	logic [DATA_W-1:0] rx_d;
	logic [3:0] bits_q;
	logic [3:0] bits_d;
	logic sck_q;
	logic sck_d;
	logic char_done;
	logic [3:0] nbits;
	logic [7:0] baud_hi_q;
	logic [7:0] baud_hi_d;
	logic [7:0] baud_lo_q;
	logic [7:0] baud_lo_d;
	logic wcol_q;
	logic wcol_d;
	logic [3:0] rise_cnt_q;
	logic [3:0] rise_cnt_d;
	logic col_q;
	logic col_d;
	logic irq_q;
	logic irq_d;
	logic ss_n_q;
	logic ss_n_d;
	logic tick;
	logic baud_run;
	logic master_on;
	logic collide_ev;
	logic modf_ev;
	logic irq_ev;
	logic slave_end;

	////////////////////////////////////////////////////////////////////////////
	// character length and divider

	always_comb begin
		if (char_length_field == '0) begin
			nbits = spieb_pkg::CHAR_MAX_BITS;
		end else begin
			nbits = {1'b0, char_length_field};
		end
	end

	// reload below the minimum is not blocked; 1 toggles the clock every cycle, 0 acts as the full count
	assign baud_divisor_reload = {baud_hi_q, baud_lo_q};
	assign master_on = spi_enable && master_mode;
	assign baud_run = (master_on && (state_q == spieb_pkg::SPIEB_SHIFT))
		|| (!spi_enable && timer_run);

	spieb_baud #(
		.WIDTH(spieb_pkg::BAUD_W)
	) u_baud (
		.clk(clk),
		.rst_n(rst_n),
		.run(baud_run),
		.reload(baud_divisor_reload),
		.tick(tick)
	);

	always_comb begin
		baud_hi_d = baud_hi_q;
		baud_lo_d = baud_lo_q;
		if (baud_hi_wr) begin
			baud_hi_d = wr_data[7:0];
		end
		if (baud_lo_wr) begin
			baud_lo_d = wr_data[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			baud_hi_q <= spieb_pkg::BAUD_RESET[15:8];
			baud_lo_q <= spieb_pkg::BAUD_RESET[7:0];
		end else begin
			baud_hi_q <= baud_hi_d;
			baud_lo_q <= baud_lo_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// master shift sequencer, mode 0 only, msb first

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		rx_d = rx_q;
		bits_d = bits_q;
		sck_d = sck_q;
		char_done = 1'b0;
		unique case (state_q)
			spieb_pkg::SPIEB_IDLE: begin
				sck_d = 1'b0;
				if (master_on && data_wr) begin
					// short characters are left aligned so the msb of the field goes first
					shift_d = DATA_W'(wr_data << (4'h8 - nbits));
					bits_d = 4'h0;
					state_d = spieb_pkg::SPIEB_SHIFT;
				end
			end
			spieb_pkg::SPIEB_SHIFT: begin
				if (!master_on) begin
					sck_d = 1'b0;
					state_d = spieb_pkg::SPIEB_IDLE;
				end else if (tick) begin
					sck_d = !sck_q;
					if (!sck_q) begin
						rx_d = {rx_q[DATA_W-2:0], miso_in};
					end else begin
						shift_d = {shift_q[DATA_W-2:0], 1'b0};
						bits_d = bits_q + 4'h1;
						if (bits_q + 4'h1 == nbits) begin
							char_done = 1'b1;
							state_d = spieb_pkg::SPIEB_IDLE;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= spieb_pkg::SPIEB_IDLE;
			shift_q <= spieb_pkg::DATA_RESET;
			rx_q <= spieb_pkg::DATA_RESET;
			bits_q <= 4'h0;
			sck_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			rx_q <= rx_d;
			bits_q <= bits_d;
			sck_q <= sck_d;
		end
	end

	assign sck_out = sck_q;
	assign sck_oe = master_on;
	assign mosi_out = shift_q[DATA_W-1];
	assign mosi_oe = master_on;
	assign rx_data = rx_q;

	always_comb begin
		rise_cnt_d = rise_cnt_q;
		if (state_q == spieb_pkg::SPIEB_IDLE) begin
			rise_cnt_d = 4'h0;
		end else if (sck_d && !sck_q) begin
			rise_cnt_d = rise_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rise_cnt_q <= 4'h0;
		end else begin
			rise_cnt_q <= rise_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// error and interrupt flags; a set in the clearing cycle wins

	// slave side has no shift engine here: busy simply follows the select pin
	assign busy = master_on ? (state_q == spieb_pkg::SPIEB_SHIFT) : (spi_enable && !ss_n_in);
	assign collide_ev = data_wr && busy;
	assign modf_ev = master_on && !ss_n_in;
	assign slave_end = spi_enable && !master_mode && !ss_n_q && ss_n_in;
	assign irq_ev = irq_enable && ((char_done)
		|| slave_end
		|| (!spi_enable && tick));

	always_comb begin
		ss_n_d = ss_n_in;
		wcol_d = wcol_q;
		col_d = col_q;
		irq_d = irq_q;
		if (stat_wr && wr_data[spieb_pkg::ST_WCOL_BIT]) begin
			wcol_d = 1'b0;
		end
		if (stat_wr && wr_data[spieb_pkg::ST_COL_BIT]) begin
			col_d = 1'b0;
		end
		if (stat_wr && wr_data[spieb_pkg::ST_IRQ_BIT]) begin
			irq_d = 1'b0;
		end
		if (collide_ev) begin
			wcol_d = 1'b1;
		end
		if (modf_ev) begin
			col_d = 1'b1;
		end
		if (irq_ev) begin
			irq_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ss_n_q <= 1'b1;
			wcol_q <= 1'b0;
			col_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ss_n_q <= ss_n_d;
			wcol_q <= wcol_d;
			col_q <= col_d;
			irq_q <= irq_d;
		end
	end

	assign irq = irq_q;

	always_comb begin
		serial_status_reg = 8'h00;
		serial_status_reg[spieb_pkg::ST_IRQ_BIT] = irq_q;
		serial_status_reg[spieb_pkg::ST_WCOL_BIT] = wcol_q;
		serial_status_reg[spieb_pkg::ST_COL_BIT] = col_q;
		serial_status_reg[spieb_pkg::ST_BUSY_BIT] = state_q == spieb_pkg::SPIEB_SHIFT;
		serial_status_reg[spieb_pkg::ST_SSIN_BIT] = ss_n_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_WCOL_SET: assert property (data_wr && busy |=> wcol_q)
		else $error("write during transfer did not set the collision flag");

	AST_WCOL_CLR: assert property (
		stat_wr && wr_data[spieb_pkg::ST_WCOL_BIT] && !(data_wr && busy) |=> !wcol_q)
		else $error("collision flag not cleared by writing one");

	AST_MODF_SET: assert property (spi_enable && master_mode && !ss_n_in |=> col_q)
		else $error("mode fault not flagged");

	AST_MODF_CLR: assert property (
		stat_wr && wr_data[spieb_pkg::ST_COL_BIT] && !modf_ev |=> !col_q)
		else $error("mode fault flag not cleared by writing one");

	AST_FLAG_HOLD: assert property (
		wcol_q && !(stat_wr && wr_data[spieb_pkg::ST_WCOL_BIT]) |=> wcol_q)
		else $error("collision flag dropped without a clear");

	AST_MASTER_IRQ: assert property (
		irq_enable && master_on && state_q == spieb_pkg::SPIEB_SHIFT
		&& state_d == spieb_pkg::SPIEB_IDLE |=> irq)
		else $error("no interrupt after master character");

	AST_CHAR_LEN: assert property (
		char_done |-> rise_cnt_q == nbits && $stable(char_length_field))
		else $error("character ended at the wrong bit count");

	AST_SLAVE_IRQ: assert property (
		!ss_n_in ##1 ss_n_in && irq_enable && spi_enable && !master_mode |=> irq)
		else $error("no interrupt when slave select rose");

	AST_IRQ_CLR: assert property (
		stat_wr && wr_data[spieb_pkg::ST_IRQ_BIT] && !irq_ev |=> !irq)
		else $error("pending interrupt not cleared");

	AST_TIMER_IRQ: assert property (
		!spi_enable && timer_run && irq_enable && tick |=> irq)
		else $error("timer time-out raised no interrupt");

	AST_SCK_ON_TICK: assert property (
		$changed(sck_out) && $past(master_on) |-> $past(tick))
		else $error("serial clock moved without a divider time-out");

	AST_RELOAD_HI: assert property (
		baud_hi_wr |=> baud_divisor_reload[15:8] == $past(wr_data[7:0]))
		else $error("high baud byte not in reload value");

	AST_HALF_PERIOD: assert property (
		tick && baud_divisor_reload == 16'h0002 && !baud_hi_wr && !baud_lo_wr
		##1 baud_run ##1 baud_run |-> tick)
		else $error("divider half period is not the reload value");

	COV_MASTER_DONE: cover property (char_done && irq_enable);
	COV_COLLISION: cover property (data_wr && busy);
	COV_SLAVE_END: cover property (slave_end);
	COV_TIMER: cover property (!spi_enable && tick);
endmodule
